/* spi_fifo_error_flags.v */
// slave serial port with receive/transmit queues and error flags
// assumes SCK, SS_N, MOSI from an external master, mode 0, msb first;
// link signals sampled by CLK, so SCK must be well below CLK/4
// master operation only silences the error flags; no link hold-off here
`timescale 1ns/10ps
`include "spi_err_consts.vh"
module spi_fifo_error_flags (
    input wire CLK,
    input wire NRST,
    input wire CE,
    input wire SCK,
    input wire SS_N,
    input wire MOSI,
    output reg MISO,
    output reg IRQ,
    input wire [3:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [3:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    localparam W = `WORD_BITS;
    localparam D = `QUEUE_DEPTH;

    wire sck_s;
    wire sel_s;
    wire mosi_s;
    spi_sync2 u_sck (.clk(CLK), .nrst(NRST), .ce(CE), .din(SCK), .dout(sck_s));
    // select synchronised active high: the flops reset to 0, which must read as idle,
    // or a false frame start would follow every reset
    spi_sync2 u_ssn (.clk(CLK), .nrst(NRST), .ce(CE), .din(~SS_N), .dout(sel_s));
    wire ssn_s = ~sel_s;
    spi_sync2 u_mosi (.clk(CLK), .nrst(NRST), .ce(CE), .din(MOSI), .dout(mosi_s));

    reg sck_d1_q;
    reg ssn_d1_q;
    wire sck_rise = sck_s & ~sck_d1_q;
    wire sck_fall = ~sck_s & sck_d1_q;
    wire frame_start = ~ssn_s & ssn_d1_q;
    wire active = ~ssn_s;

    // control and flags
    reg [1:0] flags_q;
    reg [1:0] enables_q;
    reg [2:0] control_q;
    wire rx_en = control_q[`BIT_RXEN];
    wire tx_en = control_q[`BIT_TXEN];
    wire slave_mode = control_q[`BIT_SLAVE];

    // queues: flip-flop storage indexed by pointer
    // the receive queue has no read-out path here: it fills and then stays full
    reg [W-1:0] rxq_q [0:D-1];
    reg [W-1:0] txq_q [0:D-1];
    reg rx_wp_q;
    reg rx_rp_q;
    reg [1:0] rx_cnt_q;
    reg tx_wp_q;
    reg tx_rp_q;
    reg [1:0] tx_cnt_q;
    wire rx_full = (rx_cnt_q == D);
    wire tx_empty = (tx_cnt_q == 2'h0);

    // shifter
    reg [W-1:0] sh_q;
    reg [2:0] bit_q;
    reg [W-1:0] last_rx_q;
    reg [W-1:0] rx_word;
    wire word_done = active & sck_rise & (bit_q == 3'h7);
    wire need_load = active & (frame_start | (sck_rise & (bit_q == 3'h7)));
    // a staged word counts as started only at its first rising clock; staging at
    // a word end alone must neither pop nor flag, as the frame may close there
    reg pend_q;
    reg staged_empty_q;
    wire word_begin = active & sck_rise & pend_q;

    // bus handshakes
    reg aw_got_q;
    reg w_got_q;
    reg [3:0] aw_q;
    reg [31:0] wd_q;
    // strobe kept with a data word taken ahead of its address
    reg ws0_q;
    wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID & S_AXI_WREADY;
    wire [3:0] waddr = aw_got_q ? aw_q : S_AXI_AWADDR;
    wire [31:0] wdata = w_got_q ? wd_q : S_AXI_WDATA;
    wire wr_go = (aw_got_q | aw_take) & (w_got_q | w_take) & ~S_AXI_BVALID;
    wire wr_lane0 = w_got_q ? ws0_q : S_AXI_WSTRB[0];
    wire rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
    wire rd_flags = rd_go & (S_AXI_ARADDR == `ADDR_IRQ_FLAGS);
    wire wr_txdata = wr_go & wr_lane0 & (waddr == `ADDR_STATUS) & ~(tx_cnt_q == D);
    wire rd_rxdata = rd_go & (S_AXI_ARADDR == `ADDR_STATUS + 4'h0) & 1'b0;
    wire pop_rx = rd_go & (S_AXI_ARADDR == `ADDR_CONTROL + 4'h4) & 1'b0;

    // events, gated by slave operation
    wire rxo_evt = word_done & rx_full & rx_en & slave_mode;
    // a word pushed between staging and its first clock still sees the echo go out
    wire txu_evt = word_begin & staged_empty_q & tx_en & slave_mode;
    wire rx_push = word_done & rx_en & ~rx_full;
    wire tx_pop = word_begin & ~staged_empty_q;

    always @* begin
        rx_word = {sh_q[W-2:0], mosi_s};
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sck_d1_q <= 1'b0;
            ssn_d1_q <= 1'b1;
            sh_q <= {W{1'b0}};
            bit_q <= 3'h0;
            last_rx_q <= {W{1'b0}};
            MISO <= 1'b0;
        end else if (CE) begin
            sck_d1_q <= sck_s;
            ssn_d1_q <= ssn_s;
            if (!active) begin
                bit_q <= 3'h0;
            end else if (need_load) begin
                // empty queue: echo the last word received
                sh_q <= tx_empty ? (word_done ? rx_word : last_rx_q) : txq_q[tx_rp_q];
                if (sck_rise) begin
                    bit_q <= 3'h0;
                end
                if (word_done) begin
                    last_rx_q <= rx_word;
                end
            end else if (sck_rise) begin
                sh_q <= rx_word;
                bit_q <= bit_q + 3'h1;
            end
            if (need_load) begin
                MISO <= tx_empty ? (word_done ? rx_word[W-1] : last_rx_q[W-1])
                                 : txq_q[tx_rp_q][W-1];
            end else if (active & sck_fall) begin
                MISO <= sh_q[W-1];
            end
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pend_q <= 1'b0;
            staged_empty_q <= 1'b0;
        end else if (CE) begin
            // a cut frame drops the staging; the word stays queued for the next frame
            if (!active) begin
                pend_q <= 1'b0;
            end else if (need_load) begin
                pend_q <= 1'b1;
                staged_empty_q <= tx_empty;
            end else if (sck_rise) begin
                pend_q <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < D; g = g + 1) begin : g_q
            always @(posedge CLK or negedge NRST) begin
                if (!NRST) begin
                    rxq_q[g] <= {W{1'b0}};
                    txq_q[g] <= {W{1'b0}};
                end else if (CE) begin
                    if (rx_push && rx_wp_q == g) begin
                        rxq_q[g] <= rx_word;
                    end
                    if (wr_txdata && tx_wp_q == g) begin
                        txq_q[g] <= wdata[W-1:0];
                    end
                end
            end
        end
    endgenerate

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rx_wp_q <= 1'b0;
            rx_rp_q <= 1'b0;
            rx_cnt_q <= 2'h0;
            tx_wp_q <= 1'b0;
            tx_rp_q <= 1'b0;
            tx_cnt_q <= 2'h0;
        end else if (CE) begin
            if (rx_push) begin
                rx_wp_q <= ~rx_wp_q;
            end
            if (pop_rx | rd_rxdata) begin
                rx_rp_q <= ~rx_rp_q;
            end
            rx_cnt_q <= rx_cnt_q + {1'b0, rx_push};
            if (wr_txdata) begin
                tx_wp_q <= ~tx_wp_q;
            end
            if (tx_pop) begin
                tx_rp_q <= ~tx_rp_q;
            end
            tx_cnt_q <= tx_cnt_q + {1'b0, wr_txdata} - {1'b0, tx_pop};
        end
    end

    // registers and flags; a new event beats the clear-on-read
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            flags_q <= 2'h0;
            enables_q <= `IRQ_ENABLES_RESET;
            control_q <= `CONTROL_RESET;
            IRQ <= 1'b0;
        end else if (CE) begin
            flags_q[`BIT_RXO] <= rxo_evt | (flags_q[`BIT_RXO] & ~rd_flags);
            flags_q[`BIT_TXU] <= txu_evt | (flags_q[`BIT_TXU] & ~rd_flags);
            if (wr_go && wr_lane0 && waddr == `ADDR_IRQ_ENABLES) begin
                enables_q <= wdata[1:0];
            end
            if (wr_go && wr_lane0 && waddr == `ADDR_CONTROL) begin
                control_q <= wdata[2:0];
            end
            IRQ <= |(flags_q & enables_q);
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= 4'h0;
            wd_q <= 32'h0;
            ws0_q <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= 2'h0;
        end else if (CE) begin
            S_AXI_AWREADY <= ~aw_got_q & ~aw_take & ~S_AXI_BVALID;
            S_AXI_WREADY <= ~w_got_q & ~w_take & ~S_AXI_BVALID;
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                S_AXI_AWREADY <= 1'b0;
                S_AXI_WREADY <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (waddr[3:2] == 2'h3 && tx_cnt_q == D) ? 2'h2 : 2'h0;
            end else begin
                if (aw_take) begin
                    aw_got_q <= 1'b1;
                    aw_q <= S_AXI_AWADDR;
                end
                if (w_take) begin
                    w_got_q <= 1'b1;
                    wd_q <= S_AXI_WDATA;
                    ws0_q <= S_AXI_WSTRB[0];
                end
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (rd_go) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'h0;
                case (S_AXI_ARADDR)
                    `ADDR_IRQ_FLAGS: S_AXI_RDATA <= {30'h0, flags_q};
                    `ADDR_IRQ_ENABLES: S_AXI_RDATA <= {30'h0, enables_q};
                    `ADDR_CONTROL: S_AXI_RDATA <= {29'h0, control_q};
                    `ADDR_STATUS: S_AXI_RDATA <= {16'h0, last_rx_q, 2'h0, rx_cnt_q,
                                                  2'h0, tx_cnt_q};
                    default: begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= 2'h2;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule // spi_fifo_error_flags

/* spi_err_consts.vh */
// constants for the serial port error-flag block
// assumes a 32-bit AXI4-Lite register bus, word-aligned registers
`ifndef SPI_ERR_CONSTS_VH
`define SPI_ERR_CONSTS_VH
`define ADDR_IRQ_FLAGS 4'h0
`define ADDR_IRQ_ENABLES 4'h4
`define ADDR_CONTROL 4'h8
`define ADDR_STATUS 4'hc
`define BIT_RXO 0
`define BIT_TXU 1
`define BIT_RXEN 0
`define BIT_TXEN 1
`define BIT_SLAVE 2
`define IRQ_ENABLES_RESET 2'h0
`define CONTROL_RESET 3'h0
`define WORD_BITS 8
`define QUEUE_DEPTH 2
`endif

/* spi_sync2.v */
// two-flop synchroniser for one pin level
// assumes input asynchronous to CLK
`timescale 1ns/10ps
module spi_sync2 (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire din,
    output wire dout
);
    reg s1_q;
    reg s2_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s2_q ^ (s1_q ^ s2_q);
        end
    end
    assign dout = s2_q;
endmodule // spi_sync2

/* spi_err_checker_assertions.sv */
// checker of the serial port error-flag block
// assumes a bind onto its top module, one clock domain
`timescale 1ns/10ps
module spi_err_checker (
    input wire CLK,
    input wire NRST,
    input wire SCK,
    input wire SS_N,
    input wire MISO,
    input wire IRQ,
    input wire S_AXI_AWREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    reg [3:0] lk_q, bs_q;
    // ages since a link edge and since bus activity; saturate, no wrap
    always @(posedge CLK or negedge NRST)
        if (!NRST) {lk_q, bs_q} <= 8'hff;
        else begin
            lk_q <= ($changed(SCK) || $changed(SS_N)) ? 4'h0 : lk_q + {3'h0, ~&lk_q};
            // write-address ready stands high while idle, so it marks no activity
            bs_q <= (S_AXI_ARREADY | S_AXI_BVALID | S_AXI_RVALID) ? 4'h0
                : bs_q + {3'h0, ~&bs_q};
        end
    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    a_read_answer: assert property (rd_taken |=> S_AXI_RVALID)
        else $error("read not answered");
    a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
        else $error("read answer dropped");
    a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    a_bresp_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write answered twice");
    a_aw_quiet: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("write address open while answer pending");
    a_irq_sticky: assert property ($fell(IRQ) |-> bs_q < 4'h6)
        else $error("irq fell without bus access");
    a_irq_cause: assert property ($rose(IRQ) |-> lk_q < 4'ha || bs_q < 4'h6)
        else $error("irq rose without event");
    a_miso_timing: assert property ($changed(MISO) |-> lk_q < 4'h8 || bs_q < 4'h6)
        else $error("miso moved off a link edge");
endmodule // spi_err_checker
bind spi_fifo_error_flags spi_err_checker i_chk (.*);

/* spi_master_model.sv */
// model of the external master on the serial link
// assumes mode 0, msb first, one word per frame, 160 ns clock
`timescale 1ns/10ps
module spi_master_model (
    output reg sck,
    output reg ss_n,
    output reg mosi,
    input wire miso
);
    initial {sck, ss_n, mosi} = 3'h2;
    // clock stands low between frames; data line turns over when idle
    task xfer(input [7:0] d, output [7:0] r);
        integer i;
        begin
            // step off the caller's clock edge so the synchronisers never race
            #1 ss_n = 1'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                mosi = d[i];
                #80 sck = 1'h1;
                r[i] = miso;
                #80 sck = 1'h0;
            end
            #80 ss_n = 1'h1;
            mosi = ~d[0];
            #80;
        end
    endtask
endmodule // spi_master_model

/* spi_fifo_error_flags_bench.sv */
// self-checking bench of the serial port error-flag block
// assumes the master model and the bound checker compile first
`timescale 1ns/10ps
module spi_fifo_error_flags_bench;
    reg clk = 1'h0, nrst = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    reg [3:0] aw = 4'h0, ar = 4'h0;
    reg [31:0] wd = 32'h0, seed = 32'h3c724a5b;
    reg [7:0] a, b, got;
    reg [33:0] rq[$];
    reg [1:0] bq[$];
    wire awr, wrd, bv, arr, rv, miso, irq, sck, ss_n, mosi;
    wire [1:0] bre, rre;
    wire [31:0] rdt;
    integer fails = 0, checks = 0;
    always #10 clk = ~clk;
    spi_fifo_error_flags i_dut (.CLK(clk), .NRST(nrst), .CE(1'h1), .SCK(sck), .SS_N(ss_n),
        .MOSI(mosi), .MISO(miso), .IRQ(irq), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(bre), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
        .S_AXI_RRESP(rre), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    spi_master_model i_mst (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
    task check(input [33:0] seen, exp, input string what);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    function logic [7:0] nx();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // ready to answer is raised late so the slave must hold its response
    task wr(input [3:0] ad, input [31:0] d, input [1:0] r);
        begin
            bq.push_back(r);
            @(posedge clk);
            aw <= ad;
            wd <= d;
            {awv, wv} <= 2'h3;
            do begin
                @(posedge clk);
                if (awr) awv <= 1'h0;
                if (wrd) wv <= 1'h0;
            end while (!bv);
            br <= 1'h1;
            @(posedge clk);
            br <= 1'h0;
        end
    endtask
    task rd(input [3:0] ad, input [33:0] e);
        begin
            rq.push_back(e);
            @(posedge clk);
            ar <= ad;
            arv <= 1'h1;
            do begin
                @(posedge clk);
                if (arr) arv <= 1'h0;
            end while (!rv);
            rr <= 1'h1;
            @(posedge clk);
            rr <= 1'h0;
        end
    endtask
    task frame(input [7:0] d, e);
        begin
            i_mst.xfer(d, got);
            check(got, e, "miso");
        end
    endtask
    always @(posedge clk) begin
        if (bv && br) check(bre, bq.pop_front(), "bresp");
        if (rv && rr) check({rre, rdt}, rq.pop_front(), "rdata");
    end
    task give_verdict();
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        a = nx();
        b = nx();
        wr(4'h4, 32'h3, 2'h0);
        wr(4'h8, 32'h7, 2'h0);
        wr(4'hc, {24'h0, ~a}, 2'h0);
        wr(4'hc, {24'h0, ~b}, 2'h0);
        wr(4'hc, 32'h0, 2'h2);
        frame(a, ~a);
        rd(4'h0, 34'h0);
        frame(b, ~b);
        rd(4'hc, {18'h0, b, 8'h20});
        $display("test 1 done");
        frame(nx(), b);
        check(irq, 1'h1, "irq");
        rd(4'h0, 34'h3);
        rd(4'h0, 34'h0);
        repeat (4) @(posedge clk);
        check(irq, 1'h0, "irq");
        $display("test 2 done");
        wr(4'h8, 32'h6, 2'h0);
        wr(4'h4, 32'h2, 2'h0);
        i_mst.xfer(nx(), got);
        check(irq, 1'h1, "irq");
        wr(4'h4, 32'h1, 2'h0);
        repeat (4) @(posedge clk);
        check(irq, 1'h0, "irq");
        rd(4'h0, 34'h2);
        $display("test 3 done");
        wr(4'h8, 32'h3, 2'h0);
        wr(4'h4, 32'h3, 2'h0);
        i_mst.xfer(nx(), got);
        rd(4'h0, 34'h0);
        check(irq, 1'h0, "irq");
        rd(4'h2, {2'h2, 32'h0});
        $display("test 4 done");
        give_verdict();
    end
endmodule // spi_fifo_error_flags_bench
